// >>> erx_pkg.sv
// Contract
// - full buffer drops data, flags overrun
// - client gets type, lbp and error
// - stats held until read or next frame
// - unread stats flag missed after next frame
// - running length compared with threshold
// - strip pad, never for control frames
// - four crc bytes not forwarded
// - crc32 checked, bad frames marked
// - detect vlan tag, sop and eop
// - pause address always matches
// - pause frame deleted unless filter disabled
// - pause time and request on good crc
// - lbp gives valid bytes of last word
// - accept decision on six address bytes
// - unicast filter disable is promiscuous
// - unicast matches station address
// - multicast filter disable accepts all multicast
// - multicast hash indexes 64 filter bits
// - broadcast matches unless reject enabled
// - matched frames proceed to crc check
// - unmatched frame invalidated through eop
// - lbp codes mean one to four bytes
// - hash starts all ones, six msbs
// - pause needs control type and opcode
package erx_pkg;
	localparam int ERX_DW = 32;
	localparam int ERX_WIDX_W = 12;
	localparam logic [7:0] STATION_ADDR_OFS = 8'h08;
	localparam logic [7:0] MCAST_FILTER_OFS = 8'h10;
	localparam logic [47:0] PAUSE_DA = 48'h0100_00C2_8001;
	localparam logic [47:0] BCAST_DA = 48'hFFFF_FFFF_FFFF;
	localparam logic [15:0] LT_CTRL = 16'h8808;
	localparam logic [15:0] LT_VLAN = 16'h8100;
	localparam logic [15:0] LT_MAX_LEN = 16'h0600;
	localparam logic [15:0] OPC_PAUSE = 16'h0001;
	localparam logic [15:0] HDR_BYTES = 16'h000E;
	localparam logic [15:0] PAD_THRESH_DEF = 16'h0040;
	localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY_REFL = 32'hEDB8_8320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
	localparam logic [31:0] HASH_POLY = 32'h04C1_1DB6;
	localparam logic [11:0] LT_WORD = 12'h003;
	localparam logic [11:0] PT_WORD = 12'h004;
	localparam logic [1:0] TYPE_UCAST = 2'h0;
	localparam logic [1:0] TYPE_MCAST = 2'h1;
	localparam logic [1:0] TYPE_BCAST = 2'h2;
	localparam logic [1:0] TYPE_PAUSE = 2'h3;
	localparam int STAT_W = 24;
	localparam int STAT_UCAST = 16;
	localparam int STAT_MCAST = 17;
	localparam int STAT_BCAST = 18;
	localparam int STAT_PAUSE = 19;
	localparam int STAT_VLAN = 20;
	localparam int STAT_CRCERR = 21;
	localparam int STAT_SHORT = 22;
	localparam int STAT_DROP = 23;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_W = 39;
endpackage

// >>> erx_fifo.sv
module erx_fifo #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_bad_size
		$error("erx_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr_ptr;
	logic [AW:0] next_rd_ptr;
	logic do_wr;
	logic do_rd;

	always_comb
	begin
		wr_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
		rd_valid = (wr_ptr != rd_ptr);
		rd_data = mem[rd_ptr[AW-1:0]];
		do_wr = wr_valid && wr_ready;
		do_rd = rd_valid && rd_ready;
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge clk_sys)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= wr_data;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end
endmodule // erx_fifo

// >>> erx_rx_datapath.sv
module erx_rx_datapath #(
	parameter int FIFO_DEPTH = erx_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [erx_pkg::ERX_DW-1:0] in_data,
	input wire logic in_sop,
	input wire logic in_eop,
	input wire logic [1:0] in_lbp,
	input wire logic [47:0] cfg_station_addr,
	input wire logic [63:0] cfg_mcast_hash,
	input wire logic cfg_unicast_fltr_dis,
	input wire logic cfg_mcast_fltr_dis,
	input wire logic cfg_bcast_reject,
	input wire logic cfg_ctrl_fltr_dis,
	input wire logic [15:0] cfg_pad_thresh,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [erx_pkg::ERX_DW-1:0] rx_data,
	output logic rx_sop,
	output logic rx_eop,
	output logic [1:0] rx_lbp,
	output logic rx_err,
	output logic [1:0] rx_type,
	output logic fifo_overrun,
	output logic len_short,
	output logic [erx_pkg::STAT_W-1:0] stat_vec,
	output logic stat_valid,
	input wire logic stat_rd,
	output logic stat_miss,
	output logic [15:0] pause_time,
	output logic pause_req
);
	import erx_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_FIRST, ST_PASS, ST_TRUNC, ST_DROP} erx_state_e;

	// reflected crc32 over lbp+1 valid bytes, first byte in the low lane
	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [31:0] d,
		input logic [1:0] lbp);
		logic [31:0] r;
		r = c;
		for (int k = 0; k < 4; k++)
			if (k <= int'(lbp))
				for (int b = 0; b < 8; b++)
					r = (r[0] ^ d[8*k+b]) ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
		return r;
	endfunction

	// filter bit index from the destination address
	function automatic logic [5:0] mcast_hash(input logic [47:0] da);
		logic [31:0] c;
		logic cy;
		c = CRC_INIT;
		for (int i = 0; i < 48; i++)
		begin
			cy = c[31] ^ da[i];
			c = {c[30:0], 1'b0};
			if (cy)
				c = (c ^ HASH_POLY) | 32'h0000_0001;
		end
		return c[31:26];
	endfunction

	erx_state_e st, next_st;
	logic [31:0] hold, next_hold;
	logic [ERX_WIDX_W-1:0] widx, next_widx;
	logic [ERX_WIDX_W-1:0] in_cnt, next_in_cnt;
	logic [15:0] byte_cnt, next_byte_cnt;
	logic [31:0] crc, next_crc;
	logic [15:0] lt, next_lt;
	logic lt_vld, next_lt_vld;
	logic [15:0] opc, next_opc;
	logic [15:0] ptime, next_ptime;
	logic pause_da, next_pause_da;
	logic vlan, next_vlan;
	logic [1:0] ftype, next_ftype;
	logic [1:0] trunc_lbp, next_trunc_lbp;
	logic [STAT_W-1:0] next_stat_vec;
	logic next_stat_valid, next_stat_miss;
	logic [15:0] next_pause_time;
	logic next_pause_req, next_overrun;
	logic wr_try, wr_sop, wr_eop, wr_err, fifo_wr_ready;
	logic [1:0] wr_lbp;
	logic [31:0] crc_word;
	logic crc_good, frame_end, pad_act, trunc_hit, addr_match, keep;
	logic [47:0] da;
	logic da_ucast, da_bcast, da_pause, da_mcast, mc_hit;
	logic [15:0] limit, wbase, frame_len;

	always_comb
	begin
		da = {in_data[15:0], hold};
		mc_hit = cfg_mcast_hash[mcast_hash(da)];
		da_ucast = !da[0] && (da == cfg_station_addr);
		da_bcast = (da == BCAST_DA);
		da_pause = (da == PAUSE_DA);
		da_mcast = da[0] && !da_bcast && !da_pause;
		addr_match = cfg_unicast_fltr_dis || da_pause || da_ucast
			|| (da_bcast && !cfg_bcast_reject)
			|| (da_mcast && (cfg_mcast_fltr_dis || mc_hit));
		keep = addr_match && !(da_pause && !cfg_ctrl_fltr_dis);
		crc_word = crc_upd(crc, in_data, in_eop ? in_lbp : 2'h3);
		crc_good = (crc_word == CRC_RESIDUE);
		len_short = (byte_cnt < cfg_pad_thresh);
		pad_act = lt_vld && (lt < LT_MAX_LEN) && (lt != LT_CTRL) && len_short;
		limit = HDR_BYTES + lt;
		wbase = {2'b00, widx, 2'b00};
		trunc_hit = pad_act && (limit <= wbase + 16'h0004);
		frame_len = byte_cnt + {14'h0000, in_lbp} + 16'h0001;

		next_st = st;
		next_hold = hold;
		next_widx = widx;
		next_in_cnt = in_cnt;
		next_byte_cnt = byte_cnt;
		next_crc = crc;
		next_lt = lt;
		next_lt_vld = lt_vld;
		next_opc = opc;
		next_ptime = ptime;
		next_pause_da = pause_da;
		next_vlan = vlan;
		next_ftype = ftype;
		next_trunc_lbp = trunc_lbp;
		next_stat_vec = stat_vec;
		next_stat_valid = stat_valid && !stat_rd;
		next_stat_miss = 1'b0;
		next_pause_time = pause_time;
		next_pause_req = 1'b0;
		wr_try = 1'b0;
		wr_sop = 1'b0;
		wr_eop = 1'b0;
		wr_lbp = 2'h3;
		wr_err = 1'b0;
		frame_end = 1'b0;

		if (st != ST_IDLE && in_valid)
		begin
			next_crc = crc_word;
			next_in_cnt = in_cnt + 1'b1;
			next_byte_cnt = byte_cnt + 16'h0004;
			if (in_cnt == LT_WORD)
			begin
				next_lt = {in_data[7:0], in_data[15:8]};
				next_opc = {in_data[23:16], in_data[31:24]};
				next_lt_vld = 1'b1;
				next_vlan = ({in_data[7:0], in_data[15:8]} == LT_VLAN);
			end
			if (in_cnt == PT_WORD)
				next_ptime = {in_data[7:0], in_data[15:8]};
		end

		case (st)
			ST_IDLE:
			begin
				if (in_valid && in_sop)
				begin
					next_hold = in_data;
					next_crc = crc_upd(CRC_INIT, in_data, 2'h3);
					next_in_cnt = 12'h001;
					next_widx = '0;
					next_byte_cnt = 16'h0004;
					next_lt_vld = 1'b0;
					next_vlan = 1'b0;
					next_st = ST_FIRST;
				end
			end
			ST_FIRST:
			begin
				if (in_valid)
				begin
					next_pause_da = da_pause;
					next_ftype = da_pause ? TYPE_PAUSE : da_bcast ? TYPE_BCAST :
						da[0] ? TYPE_MCAST : TYPE_UCAST;
					if (keep)
					begin
						wr_try = 1'b1;
						wr_sop = 1'b1;
						next_hold = in_data;
						next_widx = widx + 1'b1;
						next_st = ST_PASS;
					end
					else
						next_st = ST_DROP;
				end
			end
			ST_PASS:
			begin
				if (in_valid && in_eop)
				begin
					wr_try = 1'b1;
					wr_eop = 1'b1;
					wr_lbp = in_lbp;
					wr_err = !crc_good;
				end
				else if (in_valid && trunc_hit)
				begin
					next_trunc_lbp = 2'(limit - wbase - 16'h0001);
					next_st = ST_TRUNC;
				end
				else if (in_valid)
				begin
					wr_try = 1'b1;
					next_hold = in_data;
					next_widx = widx + 1'b1;
				end
			end
			ST_TRUNC:
			begin
				if (in_valid && in_eop)
				begin
					wr_try = 1'b1;
					wr_eop = 1'b1;
					wr_lbp = trunc_lbp;
					wr_err = !crc_good;
				end
			end
			ST_DROP:
			begin
				wr_try = 1'b0;
			end
			default:
				next_st = ST_IDLE;
		endcase

		if (st != ST_IDLE && in_valid && in_eop)
		begin
			frame_end = 1'b1;
			next_st = ST_IDLE;
			next_stat_vec = '0;
			next_stat_vec[15:0] = frame_len;
			next_stat_vec[STAT_UCAST] = (ftype == TYPE_UCAST);
			next_stat_vec[STAT_MCAST] = (ftype == TYPE_MCAST);
			next_stat_vec[STAT_BCAST] = (ftype == TYPE_BCAST);
			next_stat_vec[STAT_PAUSE] = pause_da;
			next_stat_vec[STAT_VLAN] = vlan;
			next_stat_vec[STAT_CRCERR] = !crc_good;
			next_stat_vec[STAT_SHORT] = (frame_len < cfg_pad_thresh);
			next_stat_vec[STAT_DROP] = (st == ST_DROP);
			next_stat_valid = 1'b1;
			next_stat_miss = stat_valid && !stat_rd;
			if (pause_da && lt_vld && lt == LT_CTRL && opc == OPC_PAUSE && crc_good)
			begin
				next_pause_req = 1'b1;
				next_pause_time = ptime;
			end
		end
		next_overrun = wr_try && !fifo_wr_ready;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st <= ST_IDLE;
			hold <= '0;
			widx <= '0;
			in_cnt <= '0;
			byte_cnt <= '0;
			crc <= CRC_INIT;
			lt <= '0;
			lt_vld <= 1'b0;
			opc <= '0;
			ptime <= '0;
			pause_da <= 1'b0;
			vlan <= 1'b0;
			ftype <= TYPE_UCAST;
			trunc_lbp <= 2'h0;
			stat_vec <= '0;
			stat_valid <= 1'b0;
			stat_miss <= 1'b0;
			pause_time <= '0;
			pause_req <= 1'b0;
			fifo_overrun <= 1'b0;
		end
		else
		begin
			st <= next_st;
			hold <= next_hold;
			widx <= next_widx;
			in_cnt <= next_in_cnt;
			byte_cnt <= next_byte_cnt;
			crc <= next_crc;
			lt <= next_lt;
			lt_vld <= next_lt_vld;
			opc <= next_opc;
			ptime <= next_ptime;
			pause_da <= next_pause_da;
			vlan <= next_vlan;
			ftype <= next_ftype;
			trunc_lbp <= next_trunc_lbp;
			stat_vec <= next_stat_vec;
			stat_valid <= next_stat_valid;
			stat_miss <= next_stat_miss;
			pause_time <= next_pause_time;
			pause_req <= next_pause_req;
			fifo_overrun <= next_overrun;
		end
	end

	// control info beside data, type decided this cycle
	erx_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_valid(wr_try),
		.wr_ready(fifo_wr_ready),
		.wr_data({next_ftype, wr_err, wr_lbp, wr_eop, wr_sop, hold}),
		.rd_valid(rx_valid),
		.rd_ready(rx_ready),
		.rd_data({rx_type, rx_err, rx_lbp, rx_eop, rx_sop, rx_data})
	);

	AST_OVERRUN: assert property (@(posedge clk_sys) disable iff (rst)
		wr_try && !fifo_wr_ready |=> fifo_overrun)
		else $error("dropped word did not raise overrun");
	AST_STAT_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		!frame_end |=> $stable(stat_vec))
		else $error("statistics vector changed without a frame end");
	AST_STAT_MISS: assert property (@(posedge clk_sys) disable iff (rst)
		frame_end && stat_valid && !stat_rd |=> stat_miss && stat_valid)
		else $error("unread vector not reported as missed");
	AST_STAT_VALID: assert property (@(posedge clk_sys) disable iff (rst)
		frame_end |=> stat_valid ##1 (stat_valid || $past(stat_rd)))
		else $error("statistics valid not raised after frame end");
	AST_PAUSE_CRC: assert property (@(posedge clk_sys) disable iff (rst)
		frame_end && !crc_good |=> !pause_req && $stable(pause_time))
		else $error("pause requested on bad crc");
	AST_LBP: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_PASS && in_valid && in_eop |-> wr_try && wr_eop && wr_lbp == in_lbp)
		else $error("last word lbp mismatch");
	AST_DROP: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_DROP |-> !wr_try)
		else $error("word written for dropped frame");
	AST_BCAST: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_FIRST && in_valid && !in_eop && da_bcast && cfg_bcast_reject
		&& !cfg_unicast_fltr_dis |=> st == ST_DROP)
		else $error("broadcast not dropped while rejected");
	AST_PAUSE_DEL: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_FIRST && in_valid && !in_eop && da_pause && !cfg_ctrl_fltr_dis
		|=> st == ST_DROP)
		else $error("pause frame forwarded with filter on");
endmodule // erx_rx_datapath

// >>> erx_client_model.sv
module erx_client_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hold,
	input wire logic rd_en,
	input wire logic stat_valid,
	output logic rx_ready,
	output logic stat_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		rx_ready = 1'b0;
		stat_rd = 1'b0;
	end
	// pops with random stalls, reads stats late
	always @(posedge clk_sys)
	begin
		rx_ready <= !rst && !hold && ($urandom % 4 != 0);
		stat_rd <= rd_en && stat_valid && !stat_rd && ($urandom % 2 == 0);
	end
endmodule // erx_client_model

// >>> erx_rx_datapath_tb_top.sv
module erx_rx_datapath_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import erx_pkg::*;
	typedef struct {logic [31:0] d; logic s; logic e; logic [1:0] l; logic r; logic [1:0] t;} erx_word_s;
	logic clk_sys = 0, rst = 1, in_valid = 0, in_sop = 0, in_eop = 0, hold = 0, rd_en = 1;
	logic cfg_unicast_fltr_dis = 0, cfg_mcast_fltr_dis = 0, cfg_bcast_reject = 0;
	logic cfg_ctrl_fltr_dis = 0, rx_valid, rx_ready, rx_sop, rx_eop, rx_err, fifo_overrun;
	logic stat_valid, stat_rd, stat_miss, pause_req, len_short;
	logic [31:0] in_data = 32'h0, rx_data, mk;
	logic [1:0] in_lbp = 2'h0, rx_lbp, rx_type;
	logic [47:0] cfg_station_addr = 48'h0;
	logic [63:0] cfg_mcast_hash = 64'h0;
	logic [15:0] cfg_pad_thresh = 16'h0040, pause_time, pv;
	logic [23:0] stat_vec, sv;
	logic [7:0] fr[$];
	erx_word_s wq[$], w;
	logic [23:0] sq[$];
	logic [15:0] pq[$];
	int num_errors = 0, checks_done = 0, nov = 0, nmiss = 0, cyc = 0, nb = 0;

	always #5 clk_sys = ~clk_sys;

	erx_rx_datapath #(.FIFO_DEPTH(FIFO_DEPTH)) erx_rx_datapath_i (.clk_sys, .rst, .in_valid,
		.in_data, .in_sop, .in_eop, .in_lbp, .cfg_station_addr, .cfg_mcast_hash,
		.cfg_unicast_fltr_dis, .cfg_mcast_fltr_dis, .cfg_bcast_reject, .cfg_ctrl_fltr_dis,
		.cfg_pad_thresh, .rx_valid, .rx_ready, .rx_data, .rx_sop, .rx_eop, .rx_lbp, .rx_err,
		.rx_type, .fifo_overrun, .len_short, .stat_vec, .stat_valid, .stat_rd, .stat_miss,
		.pause_time, .pause_req);
	erx_client_model erx_client_model_i (.clk_sys, .rst, .hold, .rd_en, .stat_valid,
		.rx_ready, .stat_rd);

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task test_done();
		chk(wq.size() + sq.size() + pq.size(), 0, "results left over");
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task nxt();
		@(posedge clk_sys);
		in_valid <= 0;
		in_sop <= 0;
		in_eop <= 0;
	endtask

	function automatic logic [31:0] fcs_of();
		logic [31:0] c;
		c = CRC_INIT;
		foreach (fr[i])
		begin
			c ^= {24'h0, fr[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
		end
		return ~c;
	endfunction

	function automatic logic [5:0] hidx(input logic [47:0] a);
		logic [31:0] c;
		logic k;
		c = CRC_INIT;
		for (int i = 0; i < 48; i++)
		begin
			k = c[31] ^ a[i];
			c = c << 1;
			if (k)
				c = (c ^ HASH_POLY) | 32'h1;
		end
		return c[31:26];
	endfunction

	// builds one frame, notes expected words, stats and pause, then sends it
	task automatic frm(input logic [47:0] da, input logic [15:0] lt, input int plen,
		input logic bad, input int lim = 64);
		logic [31:0] d;
		logic m;
		logic [1:0] ty;
		int n, no;
		erx_word_s x;
		fr = {};
		for (int i = 0; i < 6; i++) fr.push_back(da[8*i+:8]);
		repeat (6) fr.push_back(8'($urandom));
		fr.push_back(lt[15:8]);
		fr.push_back(lt[7:0]);
		repeat (plen) fr.push_back(8'($urandom));
		if (lt == LT_CTRL)
		begin
			fr[14] = OPC_PAUSE[15:8];
			fr[15] = OPC_PAUSE[7:0];
		end
		d = fcs_of() ^ {32{bad}};
		for (int i = 0; i < 4; i++) fr.push_back(d[8*i+:8]);
		n = fr.size();
		ty = da == PAUSE_DA ? TYPE_PAUSE : da == BCAST_DA ? TYPE_BCAST : da[0] ? TYPE_MCAST
			: TYPE_UCAST;
		m = cfg_unicast_fltr_dis || ty == TYPE_PAUSE || (ty == TYPE_BCAST && !cfg_bcast_reject)
			|| (ty == TYPE_UCAST && da == cfg_station_addr)
			|| (ty == TYPE_MCAST && (cfg_mcast_fltr_dis || cfg_mcast_hash[hidx(da)]));
		no = (lt < LT_MAX_LEN && lt != LT_CTRL && 14 + lt < n - 4) ? 14 + lt : n - 4;
		if (m && (ty != TYPE_PAUSE || cfg_ctrl_fltr_dis))
			for (int i = 0; i < no && i / 4 < lim; i += 4)
			begin
				x = '{{fr[i+3], fr[i+2], fr[i+1], fr[i]}, i == 0, i + 4 >= no, 2'(no - 1 - i), bad, ty};
				wq.push_back(x);
			end
		sq.push_back({!(m && (ty != TYPE_PAUSE || cfg_ctrl_fltr_dis)), n < cfg_pad_thresh, bad,
			lt == LT_VLAN, ty == TYPE_PAUSE, ty == TYPE_BCAST, ty == TYPE_MCAST, ty == TYPE_UCAST,
			16'(n)});
		if (ty == TYPE_PAUSE && lt == LT_CTRL && !bad)
			pq.push_back({fr[16], fr[17]});
		for (int i = 0; i < n; i += 4)
		begin
			if (i > 0 && $urandom % 4 == 0)
				nxt();
			for (int j = 0; j < 4; j++) d[8*j+:8] = (i + j < n) ? fr[i+j] : 8'($urandom);
			@(posedge clk_sys);
			in_valid <= 1;
			in_data <= d;
			in_sop <= i == 0;
			in_eop <= i + 4 >= n;
			in_lbp <= 2'(n - 1 - i);
		end
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			$display("[FAIL] %0t run did not finish", $time);
			test_done();
		end
	end

	always @(posedge clk_sys)
		if (!rst)
		begin
			nov += fifo_overrun;
			nmiss += stat_miss;
			if (in_valid && !in_sop)
				chk(len_short, nb < cfg_pad_thresh, "short");
			if (in_valid)
				nb = in_sop ? 4 : nb + 4;
			if (rx_valid && rx_ready)
			begin
				w = wq.size() ? wq.pop_front() : '{default: 'x};
				mk = w.e ? 32'hFFFF_FFFF >> (8 * (3 - w.l)) : 32'hFFFF_FFFF;
				chk(rx_data & mk, w.d & mk, "data");
				chk({rx_sop, rx_eop, rx_type}, {w.s, w.e, w.t}, "ctl");
				if (w.e)
					chk({rx_lbp, rx_err}, {w.l, w.r}, "end");
			end
			if (stat_valid && (!$past(stat_valid) || stat_miss || $past(stat_rd)))
			begin
				sv = sq.size() ? sq.pop_front() : 'x;
				chk(stat_vec, sv, "stats");
			end
			else if (stat_valid)
				chk(stat_vec, $past(stat_vec), "stats hold");
			if (pause_req)
			begin
				pv = pq.size() ? pq.pop_front() : 'x;
				chk(pause_time, pv, "pause");
			end
		end

	initial
	begin
		void'($urandom(11));
		repeat (5) @(posedge clk_sys);
		rst <= 0;
		cfg_station_addr <= 48'({$urandom, $urandom}) & 48'hFFFF_FFFF_FFFE;
		cfg_mcast_hash <= {$urandom, $urandom};
		nxt();
		for (int k = 0; k < 4; k++) frm(cfg_station_addr, 16'h0800, 46 + k, 0);
		frm(cfg_station_addr ^ 48'h0000_0000_0100, 16'h0800, 50, 0);
		cfg_unicast_fltr_dis <= 1;
		nxt();
		frm(cfg_station_addr ^ 48'h0000_0000_0100, 16'h0800, 50, 0);
		cfg_unicast_fltr_dis <= 0;
		nxt();
		for (int k = 0; k < 8; k++) frm(48'({$urandom, $urandom}) | 48'h1, 16'h0800, 46, 0);
		cfg_mcast_fltr_dis <= 1;
		nxt();
		frm(48'({$urandom, $urandom}) | 48'h1, 16'h0800, 46, 0);
		cfg_mcast_fltr_dis <= 0;
		cfg_mcast_hash <= 64'h0;
		for (int k = 0; k < 2; k++)
		begin
			nxt();
			cfg_bcast_reject <= 1'(k);
			nxt();
			frm(BCAST_DA, 16'h0800, 46, 0);
		end
		frm(cfg_station_addr, 16'h0800, 50, 1);
		for (int k = 0; k < 2; k++)
		begin
			nxt();
			cfg_ctrl_fltr_dis <= 1'(k);
			nxt();
			frm(PAUSE_DA, LT_CTRL, 46, 0);
		end
		frm(PAUSE_DA, LT_CTRL, 46, 1);
		frm(PAUSE_DA, 16'h0800, 46, 0);
		frm(cfg_station_addr, 16'h000A, 46, 0);
		frm(cfg_station_addr, LT_CTRL, 46, 0);
		frm(cfg_station_addr, LT_VLAN, 60, 0);
		repeat (3) nxt();
		while (stat_valid) nxt();
		rd_en <= 0;
		frm(cfg_station_addr, 16'h0800, 46, 0);
		frm(cfg_station_addr, 16'h0800, 46, 0);
		repeat (3) nxt();
		chk(nmiss, 1, "stats missed");
		rd_en <= 1;
		while (rx_valid) nxt();
		hold <= 1;
		nxt();
		frm(cfg_station_addr, 16'h0800, 162, 0, FIFO_DEPTH);
		repeat (4) nxt();
		chk(nov, 12, "overrun count");
		hold <= 0;
		while (wq.size()) nxt();
		frm(cfg_station_addr, 16'h0800, 47, 0);
		while (wq.size() || sq.size() || pq.size()) nxt();
		repeat (4) nxt();
		test_done();
	end
endmodule // erx_rx_datapath_tb_top
